/* core/sfp_device_end.sv */
/*
 * Flash device end: serial command decoder with two page buffers on
 * the link clock, and the program sequencer on the system clock.
 * Assumes the link clock stops between frames and that
 * binary_page_mode is stable while a frame or an operation runs.
 */
`timescale 1ns/1ps
// Contract
// - Buffer load opcodes 84h and 87h
// - Standard load address: 15 ignored, 9-bit index
// - Binary load address: 16 ignored, 8-bit index
// - Data bytes stored successively until deselect
// - Buffer load wraps to first location
// - Erase-and-program opcodes 83h and 86h
// - Standard program address: 3, 12 page, 9
// - Binary program address: 4, 12 page, 8
// - Deselect erases page then programs buffer
// - Busy reported while erase or program runs
// - Failed byte sets the error flag
// - Program without erase opcodes 88h, 89h
// - Deselect programs page without erasing
// - Host targets only erased pages without erase
// - Load-program-erase 82h/85h, page and index
// - Binary load-program: 4, 12 page, 8 index
// - Load buffer, then erase and program
// - Opcode 02h programs via first buffer
// - Byte program takes 1 to page size
// - Only received bytes reach the array
// - Partial byte at deselect aborts program
// - Binary page and index form linear address
module sfp_device_end #(
    parameter int unsigned BUF_DEPTH = sfp_pkg::PAGE_STD
) (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Serial link
    sfp_link_if.device       link,
    // Configuration and status
    input  wire logic        binary_page_mode,
    output logic             ready_busy,
    output logic             erase_program_error_flag,
    // Main array
    output logic             mem_erase_req,
    output logic             mem_write_req,
    output logic [11:0]      mem_page,
    output logic [8:0]       mem_byte,
    output logic [7:0]       mem_data,
    input  wire logic        mem_done,
    input  wire logic        mem_fail
);
    if (BUF_DEPTH < sfp_pkg::PAGE_STD) begin : g_depth_check
        $error("BUF_DEPTH must hold a standard page");
    end

    // ************************************************************
    // Link domain
    // ************************************************************
    logic [7:0]  buf1 [BUF_DEPTH];
    logic [7:0]  buf2 [BUF_DEPTH];
    logic [1:0]  mode_sync;
    logic        fresh;
    logic        frame_tog;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [6:0]  shreg;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [8:0]  ptr;
    logic [8:0]  count;
    logic [2:0]  eff_bit;
    logic [2:0]  eff_byte;
    logic        byte_end;
    logic [7:0]  rx_byte;
    logic [23:0] hdr_word;
    logic [8:0]  start_idx;
    logic [8:0]  link_depth;
    logic [8:0]  next_ptr;
    logic        load_wr;

    // Mode strap into the link domain
    always_ff @(posedge link.sck or negedge resetn) begin
        if (!resetn) begin
            mode_sync <= 2'b00;
        end else begin
            mode_sync <= {mode_sync[0], binary_page_mode};
        end
    end

    // Marks the first edge of a frame; deselect sets it without any edge
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Framing and field decode
    assign eff_bit    = fresh ? 3'h0 : bit_cnt;
    assign eff_byte   = fresh ? 3'h0 : byte_cnt;
    assign byte_end   = eff_bit == sfp_pkg::LAST_BIT;
    assign rx_byte    = {shreg, link.si};
    assign hdr_word   = {addr[15:0], rx_byte};
    assign start_idx  = mode_sync[1] ? {1'b0, hdr_word[7:0]} : hdr_word[8:0];
    assign link_depth = mode_sync[1] ? sfp_pkg::PAGE_BIN_BYTES : sfp_pkg::PAGE_STD_BYTES;
    assign next_ptr   = (ptr >= link_depth - 9'h001) ? 9'h000 : ptr + 9'h001;
    assign load_wr    = byte_end && eff_byte == sfp_pkg::DATA_PHASE && sfp_pkg::sfp_loads(opcode);

    // Serial shifter and command capture on rising edges
    always_ff @(posedge link.sck or negedge resetn) begin
        if (!resetn) begin
            frame_tog <= 1'b0;
            bit_cnt   <= 3'h0;
            byte_cnt  <= 3'h0;
            shreg     <= 7'h00;
            opcode    <= 8'h00;
            addr      <= 24'h000000;
            ptr       <= 9'h000;
            count     <= 9'h000;
        end else begin
            frame_tog <= frame_tog ^ fresh;
            bit_cnt   <= eff_bit + 3'h1;
            byte_cnt  <= eff_byte;
            shreg     <= {shreg[5:0], link.si};
            if (byte_end) begin
                if (eff_byte != sfp_pkg::DATA_PHASE) begin
                    byte_cnt <= eff_byte + 3'h1;
                end
                if (eff_byte == 3'h0) begin
                    opcode <= rx_byte;
                end else if (eff_byte != sfp_pkg::DATA_PHASE) begin
                    addr <= hdr_word;
                end
                if (eff_byte == sfp_pkg::HDR_BYTES - 3'h1) begin
                    ptr   <= start_idx;
                    count <= 9'h000;
                end else if (load_wr) begin
                    ptr   <= next_ptr;
                    count <= (count == link_depth) ? count : count + 9'h001;
                end
            end
        end
    end

    // Buffer stores; byte program always goes through the first buffer
    always_ff @(posedge link.sck) begin
        if (load_wr && sfp_pkg::sfp_second_buf(opcode)) begin
            buf2[ptr] <= rx_byte;
        end
        if (load_wr && !sfp_pkg::sfp_second_buf(opcode)) begin
            buf1[ptr] <= rx_byte;
        end
    end

    // ************************************************************
    // System domain
    // ************************************************************
    logic [1:0]  cs_sync;
    logic [1:0]  tog_sync;
    logic        cs_prev;
    logic        seen_tog;
    logic        deselect;
    logic        had_edges;
    logic        hdr_done;
    logic        aligned;
    logic        is_byte_prog;
    logic        start;
    logic        busy;
    logic [11:0] page_field;
    logic [8:0]  idx_field;
    logic [8:0]  sys_depth;
    logic [8:0]  buf_addr;
    logic [7:0]  buf_data;

    // Deselect and frame toggle crossings
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cs_sync  <= 2'b11;
            tog_sync <= 2'b00;
            cs_prev  <= 1'b1;
            seen_tog <= 1'b0;
        end else begin
            cs_sync  <= {cs_sync[0], link.cs_n};
            tog_sync <= {tog_sync[0], frame_tog};
            cs_prev  <= cs_sync[1];
            if (deselect) begin
                seen_tog <= tog_sync[1];
            end
        end
    end

    // Link-side words are read only after deselect, while the link clock
    // stands still, so they are static here; the synced toggle proves
    // that this frame actually clocked them.
    assign deselect     = cs_sync[1] && !cs_prev;
    assign had_edges    = tog_sync[1] != seen_tog;
    assign hdr_done     = byte_cnt == sfp_pkg::DATA_PHASE;
    assign aligned      = bit_cnt == 3'h0;
    assign is_byte_prog = opcode == sfp_pkg::OP_BYTE_PROG;
    assign sys_depth    = binary_page_mode ? sfp_pkg::PAGE_BIN_BYTES : sfp_pkg::PAGE_STD_BYTES;
    assign page_field   = binary_page_mode ? addr[sfp_pkg::BIN_PAGE_LSB +: sfp_pkg::PAGE_W]
                                           : addr[sfp_pkg::STD_PAGE_LSB +: sfp_pkg::PAGE_W];
    // Binary mode: {page_field, idx_field[7:0]} is the 20-bit linear address
    assign idx_field    = binary_page_mode ? {1'b0, addr[7:0]} : addr[8:0];
    // Start refused while busy; partial byte or no data aborts byte program
    assign start        = deselect && had_edges && hdr_done && !busy && sfp_pkg::sfp_programs(opcode)
                          && (!is_byte_prog || (aligned && count != 9'h000));

    assign buf_data     = sfp_pkg::sfp_second_buf(opcode) ? buf2[buf_addr] : buf1[buf_addr];
    assign ready_busy   = !busy;

    sfp_program_engine u_engine (
        .clock         (clock),
        .resetn        (resetn),
        .start         (start),
        .erase         (sfp_pkg::sfp_erases(opcode)),
        .page          (page_field),
        .first         (is_byte_prog ? idx_field : 9'h000),
        .count         (is_byte_prog ? count : sys_depth),
        .page_bytes    (sys_depth),
        .busy          (busy),
        .error         (erase_program_error_flag),
        .buf_addr      (buf_addr),
        .buf_data      (buf_data),
        .mem_erase_req (mem_erase_req),
        .mem_write_req (mem_write_req),
        .mem_page      (mem_page),
        .mem_byte      (mem_byte),
        .mem_data      (mem_data),
        .mem_done      (mem_done),
        .mem_fail      (mem_fail)
    );
endmodule // sfp_device_end

/* core/sfp_host_end.sv */
/*
 * Host controller end: frames one command with its address bytes and
 * optional data bytes onto the link, making the link clock by division.
 * Assumes the user holds cmd fields while cmd_valid and supplies
 * exactly cmd_length data bytes on the write stream.
 */
`timescale 1ns/1ps
module sfp_host_end #(
    parameter int unsigned HALF = sfp_pkg::HALF_CYCLES
) (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Serial link
    sfp_link_if.host         link,
    // Command request
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [11:0] cmd_page_index,
    input  wire logic [8:0]  cmd_byte_index,
    input  wire logic        cmd_binary,
    input  wire logic [8:0]  cmd_length,
    // Data bytes
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [7:0]  wr_data
);
    if (HALF < 1 || HALF > 255) begin : g_half_check
        $error("HALF must be 1 to 255");
    end

    typedef enum logic [2:0] {
        SFP_H_IDLE  = 3'b001,
        SFP_H_SHIFT = 3'b010,
        SFP_H_GUARD = 3'b100
    } sfp_host_t;

    sfp_host_t   state;
    logic [7:0]  div;
    logic        sck;
    logic        cs_n;
    logic [7:0]  sh;
    logic [2:0]  bit_i;
    logic        need;
    logic [23:0] hdr;
    logic [2:0]  hdr_left;
    logic [8:0]  data_left;
    logic        wrap;
    logic        slot;
    logic [23:0] addr_word;

    // Address layout per command and page mode; ignored bits sent as zero
    assign addr_word = !sfp_pkg::sfp_programs(cmd_opcode)
        ? (cmd_binary ? {16'h0000, cmd_byte_index[7:0]}
                      : {15'h0000, cmd_byte_index})
        : !sfp_pkg::sfp_loads(cmd_opcode)
        ? (cmd_binary ? {4'h0, cmd_page_index, 8'h00}
                      : {3'h0, cmd_page_index, 9'h000})
        : (cmd_binary ? {4'h0, cmd_page_index, cmd_byte_index[7:0]}
                      : {3'h0, cmd_page_index, cmd_byte_index});

    // Handshakes and pins
    assign wrap      = div == 8'(HALF - 1);
    assign slot      = state == SFP_H_SHIFT && wrap && !sck && need;
    assign cmd_ready = state == SFP_H_IDLE;
    assign wr_ready  = slot && hdr_left == 3'h0 && data_left != 9'h000;
    assign link.sck  = sck;
    assign link.cs_n = cs_n;
    assign link.si   = sh[7];

    // Framing; the caller only sends a no-erase program to an erased page
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state     <= SFP_H_IDLE;
            div       <= 8'h00;
            sck       <= 1'b0;
            cs_n      <= 1'b1;
            sh        <= 8'h00;
            bit_i     <= 3'h0;
            need      <= 1'b0;
            hdr       <= 24'h000000;
            hdr_left  <= 3'h0;
            data_left <= 9'h000;
        end else begin
            div <= wrap ? 8'h00 : div + 8'h01;
            unique case (state)
                SFP_H_IDLE: begin
                    div <= 8'h00;
                    if (cmd_valid) begin
                        cs_n      <= 1'b0;
                        sh        <= cmd_opcode;
                        hdr       <= addr_word;
                        hdr_left  <= sfp_pkg::HDR_BYTES - 3'h1;
                        data_left <= sfp_pkg::sfp_loads(cmd_opcode) ? cmd_length : 9'h000;
                        bit_i     <= 3'h0;
                        need      <= 1'b0;
                        state     <= SFP_H_SHIFT;
                    end
                end
                SFP_H_SHIFT: if (wrap) begin
                    if (sck) begin
                        // Falling edge: next bit, or ask for the next byte
                        sck   <= 1'b0;
                        bit_i <= bit_i + 3'h1;
                        if (bit_i == sfp_pkg::LAST_BIT) begin
                            need <= 1'b1;
                        end else begin
                            sh <= {sh[6:0], 1'b0};
                        end
                    end else if (!need) begin
                        sck <= 1'b1;
                    end else if (hdr_left != 3'h0) begin
                        sh       <= hdr[23:16];
                        hdr      <= {hdr[15:0], 8'h00};
                        hdr_left <= hdr_left - 3'h1;
                        need     <= 1'b0;
                    end else if (data_left != 9'h000) begin
                        if (wr_valid) begin
                            sh        <= wr_data;
                            data_left <= data_left - 9'h001;
                            need      <= 1'b0;
                        end
                    end else begin
                        cs_n  <= 1'b1;
                        state <= SFP_H_GUARD;
                    end
                end
                SFP_H_GUARD: if (wrap) begin
                    state <= SFP_H_IDLE;
                end
                default: state <= SFP_H_IDLE;
            endcase
        end
    end
endmodule // sfp_host_end

/* core/sfp_link_if.sv */
/*
 * Serial link between host controller and flash device.
 * Assumes the host end drives all three wires.
 */
`timescale 1ns/1ps
interface sfp_link_if;
    logic sck;
    logic cs_n;
    logic si;
    modport host (output sck, output cs_n, output si);
    modport device (input sck, input cs_n, input si);
endinterface

/* core/sfp_pkg.sv */
/*
 * Shared constants for the serial flash program sequencer: opcodes,
 * page geometry, address field positions and link timing.
 * Assumes both ends refer to it as sfp_pkg::name; the bench uses its own literal values.
 */
package sfp_pkg;
    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_LOAD_B1     = 8'h84;
    localparam logic [7:0] OP_LOAD_B2     = 8'h87;
    localparam logic [7:0] OP_PROG_ERS_B1 = 8'h83;
    localparam logic [7:0] OP_PROG_ERS_B2 = 8'h86;
    localparam logic [7:0] OP_PROG_RAW_B1 = 8'h88;
    localparam logic [7:0] OP_PROG_RAW_B2 = 8'h89;
    localparam logic [7:0] OP_LDPR_ERS_B1 = 8'h82;
    localparam logic [7:0] OP_LDPR_ERS_B2 = 8'h85;
    localparam logic [7:0] OP_BYTE_PROG   = 8'h02;

    // ************************************************************
    // Geometry and fields
    // ************************************************************
    localparam int unsigned PAGE_STD       = 264;
    localparam logic [8:0]  PAGE_STD_BYTES = 9'h108;
    localparam logic [8:0]  PAGE_BIN_BYTES = 9'h100;
    localparam int unsigned PAGE_W         = 12;
    localparam int unsigned IDX_W          = 9;
    localparam int unsigned STD_PAGE_LSB   = 9;
    localparam int unsigned BIN_PAGE_LSB   = 8;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    localparam logic [2:0]  HDR_BYTES      = 3'h4;
    localparam logic [2:0]  DATA_PHASE     = 3'h4;

    // ************************************************************
    // Link timing
    // ************************************************************
    localparam int unsigned CLOCK_PERIOD_NS = 4;
    localparam int unsigned LINK_PERIOD_NS  = 48;
    localparam int unsigned HALF_CYCLES     = LINK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);

    // Commands that store data bytes in a buffer
    function automatic logic sfp_loads(input logic [7:0] op);
        return op == OP_LOAD_B1 || op == OP_LOAD_B2 || op == OP_LDPR_ERS_B1
            || op == OP_LDPR_ERS_B2 || op == OP_BYTE_PROG;
    endfunction

    // Commands that carry a page index
    function automatic logic sfp_programs(input logic [7:0] op);
        return op == OP_PROG_ERS_B1 || op == OP_PROG_ERS_B2 || op == OP_PROG_RAW_B1
            || op == OP_PROG_RAW_B2 || op == OP_LDPR_ERS_B1 || op == OP_LDPR_ERS_B2
            || op == OP_BYTE_PROG;
    endfunction

    function automatic logic sfp_erases(input logic [7:0] op);
        return op == OP_PROG_ERS_B1 || op == OP_PROG_ERS_B2
            || op == OP_LDPR_ERS_B1 || op == OP_LDPR_ERS_B2;
    endfunction

    function automatic logic sfp_second_buf(input logic [7:0] op);
        return op == OP_LOAD_B2 || op == OP_PROG_ERS_B2
            || op == OP_PROG_RAW_B2 || op == OP_LDPR_ERS_B2;
    endfunction
endpackage

/* core/sfp_program_engine.sv */
/*
 * Self-timed erase/program sequencer on the system clock.
 * Assumes the array answers each request with a one-cycle mem_done
 * pulse, mem_fail valid with it, and that buf_data follows buf_addr
 * combinationally.
 */
`timescale 1ns/1ps
module sfp_program_engine (
    // System
    input  wire logic        clock,
    input  wire logic        resetn,
    // Command
    input  wire logic        start,
    input  wire logic        erase,
    input  wire logic [11:0] page,
    input  wire logic [8:0]  first,
    input  wire logic [8:0]  count,
    input  wire logic [8:0]  page_bytes,
    output logic             busy,
    output logic             error,
    // Buffer read
    output logic [8:0]       buf_addr,
    input  wire logic [7:0]  buf_data,
    // Array
    output logic             mem_erase_req,
    output logic             mem_write_req,
    output logic [11:0]      mem_page,
    output logic [8:0]       mem_byte,
    output logic [7:0]       mem_data,
    input  wire logic        mem_done,
    input  wire logic        mem_fail
);
    typedef enum logic [3:0] {
        SFP_IDLE  = 4'b0001,
        SFP_ERASE = 4'b0010,
        SFP_READ  = 4'b0100,
        SFP_WRITE = 4'b1000
    } sfp_eng_t;

    sfp_eng_t   state;
    logic [8:0] left;
    logic [8:0] wrap;
    logic [8:0] next_byte;

    // Byte walk wraps at the page end
    assign next_byte     = (mem_byte + 9'h001 >= wrap) ? 9'h000 : mem_byte + 9'h001;
    assign busy          = state != SFP_IDLE;
    assign buf_addr      = mem_byte;
    assign mem_erase_req = state == SFP_ERASE;
    assign mem_write_req = state == SFP_WRITE;

    // Sequencer; error clears only at a new start, so no set can collide
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state    <= SFP_IDLE;
            left     <= 9'h000;
            wrap     <= 9'h000;
            error    <= 1'b0;
            mem_page <= 12'h000;
            mem_byte <= 9'h000;
            mem_data <= 8'h00;
        end else begin
            unique case (state)
                SFP_IDLE: if (start) begin
                    error    <= 1'b0;
                    mem_page <= page;
                    mem_byte <= first;
                    left     <= count;
                    wrap     <= page_bytes;
                    state    <= erase ? SFP_ERASE : SFP_READ;
                end
                SFP_ERASE: if (mem_done) begin
                    error <= error | mem_fail;
                    state <= SFP_READ;
                end
                SFP_READ: begin
                    mem_data <= buf_data;
                    state    <= SFP_WRITE;
                end
                SFP_WRITE: if (mem_done) begin
                    error    <= error | mem_fail;
                    left     <= left - 9'h001;
                    mem_byte <= next_byte;
                    state    <= (left == 9'h001) ? SFP_IDLE : SFP_READ;
                end
            endcase
        end
    end
endmodule // sfp_program_engine

/* tb/sfp_link_chk.sv */
/* Checker on the serial link: clock phases, framing, byte counts.
   Assumes the host end runs with HALF of 2. */
`timescale 1ns/1ps
module sfp_link_chk (
    // System
    input wire logic clock,
    input wire logic resetn,
    // Link wires
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si
);
    // ****************
    // Bit counter
    // ****************
    logic [11:0] bits;
    logic        sck_q;
    // Rising link edges per frame; cleared while deselected
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bits  <= 12'h000;
            sck_q <= 1'b0;
        end else begin
            bits  <= cs_n ? 12'h000 : bits + {11'h000, sck & ~sck_q};
            sck_q <= sck;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Half periods of the divided clock
    sequence s_hi; sck [*2]; endsequence
    sequence s_lo; !sck [*2]; endsequence
    a_sck_idle: assert property (cs_n |-> !sck) else $error("clock moved while idle");
    a_si_steady: assert property (sck && $past(sck) |-> $stable(si)) else $error("data moved");
    a_high_half: assert property ($rose(sck) |-> s_hi ##1 !sck) else $error("high phase wrong");
    a_low_half: assert property ($fell(sck) |-> s_lo) else $error("low phase short");
    a_cs_lead: assert property ($fell(cs_n) |-> s_lo ##1 sck) else $error("first edge misplaced");
    a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*3]) else $error("deselect gap short");
    a_byte_whole: assert property ($rose(cs_n) |-> bits[2:0] == 3'h0) else $error("partial byte");
    a_hdr_whole: assert property ($rose(cs_n) |-> bits >= 12'h020) else $error("short header");
endmodule // sfp_link_chk

/* tb/tb.sv */
/* Bench: host end drives device end; bench models the array and
   scores every array access against queued notes.
   Assumes package, link interface and checker compiled first. */
`timescale 1ns/1ps
module tb;
    logic        clock = 1'b0, resetn = 1'b0, bin = 1'b0, fail_en = 1'b0, dq = 1'b0;
    logic        cmd_valid = 1'b0, wr_valid = 1'b0, mem_done = 1'b0, mem_fail = 1'b0;
    logic [7:0]  cmd_opcode = 8'h00, wr_data = 8'h00;
    logic [11:0] cmd_page_index = 12'h000, mem_page;
    logic [8:0]  cmd_byte_index = 9'h000, cmd_length = 9'h000, mem_byte;
    logic        cmd_ready, wr_ready, ready_busy, erase_program_error_flag, mem_erase_req, mem_write_req;
    logic [7:0]  mem_data, b [2][264], ops [4] = '{8'h83, 8'h86, 8'h88, 8'h89};
    logic [31:0] hdr = 32'h0;
    logic [5:0]  hn = 6'h00;
    logic        sq = 1'b0;
    logic [29:0] q [$];
    int          bad_count = 0, comparisons = 0;
    sfp_link_if link ();
    sfp_host_end #(.HALF(2)) i_sfp_host_end (.clock, .resetn, .link(link.host), .cmd_valid, .cmd_ready,
        .cmd_opcode, .cmd_page_index, .cmd_byte_index, .cmd_binary(bin), .cmd_length, .wr_valid,
        .wr_ready, .wr_data);
    sfp_device_end i_sfp_device_end (.clock, .resetn, .link(link.device), .binary_page_mode(bin),
        .ready_busy, .erase_program_error_flag, .mem_erase_req, .mem_write_req, .mem_page, .mem_byte,
        .mem_data, .mem_done, .mem_fail);
    sfp_link_chk i_sfp_link_chk (.clock, .resetn, .sck(link.sck), .cs_n(link.cs_n), .si(link.si));
    always #2 clock = ~clock;
    // Array answers after a random wait, never twice in a row
    always @(posedge clock) begin
        mem_done <= (mem_erase_req | mem_write_req) & ~mem_done & ~dq & $urandom % 2 == 0;
        dq <= mem_done;
        mem_fail <= fail_en;
    end
    // Scoreboard: each answered access takes the oldest note
    always @(posedge clock) if (mem_done) begin
        cmp({mem_write_req, mem_page, mem_write_req ? {mem_byte, mem_data} : 17'h00000});
        chk(32'h0, {31'h0, ready_busy});
    end
    // Shadow of each frame's header, taken on rising link edges
    always @(posedge clock) begin
        sq <= link.sck;
        if (link.cs_n) hn <= 6'h00;
        else if (link.sck & ~sq & hn < 6'h20) begin
            hdr <= {hdr[30:0], link.si};
            hn <= hn + 6'h01;
        end
    end
    task automatic fail(input string m);
        bad_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp(input logic [29:0] g);
        logic [29:0] e;
        comparisons++;
        e = q.size() ? q.pop_front() : 'x;
        if (e !== g) fail("array access differs");
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (e !== g) fail("value differs");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One frame, its notes, then wait for the array to settle
    task automatic run(input logic [7:0] op, input logic [11:0] pg, input logic [8:0] ix, input int n);
        int sz, k;
        logic s2, pg_on;
        logic [7:0] d;
        logic [31:0] mk;
        sz = bin ? 256 : 264;
        s2 = op == 8'h87 || op == 8'h86 || op == 8'h89 || op == 8'h85;
        pg_on = op != 8'h84 && op != 8'h87;
        mk = 32'hFF000000 | (pg_on ? (bin ? 32'h000FFF00 : 32'h001FFE00) : 32'h0);
        if (!(op inside {8'h83, 8'h86, 8'h88, 8'h89})) mk = mk | (bin ? 32'h000000FF : 32'h000001FF);
        cmd_opcode <= op;
        cmd_page_index <= pg;
        cmd_byte_index <= ix;
        cmd_length <= 9'(n);
        cmd_valid <= 1'b1;
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (k = 0; k < n; k++) begin
            d = 8'($urandom);
            b[s2][(ix + k) % sz] = d;
            wr_data <= d;
            wr_valid <= 1'b1;
            do @(posedge clock); while (wr_ready !== 1'b1);
        end
        wr_valid <= 1'b0;
        if (op inside {8'h83, 8'h86, 8'h82, 8'h85}) q.push_back({1'b0, pg, 17'h00000});
        if (op == 8'h02) for (k = 0; k < n; k++) q.push_back({1'b1, pg, 9'((ix + k) % sz), b[0][(ix + k) % sz]});
        else if (pg_on && op != 8'h84) for (k = 0; k < sz; k++) q.push_back({1'b1, pg, 9'(k), b[s2][k]});
        do @(posedge clock); while (cmd_ready !== 1'b1);
        chk((bin ? {op, 4'h0, pg, ix[7:0]} : {op, 3'h0, pg, ix}) & mk, hdr & mk);
        do @(posedge clock); while (q.size() != 0 || ready_busy !== 1'b1);
    endtask
    initial begin
        void'($urandom(29518));
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        bin <= 1'b1;
        @(posedge clock); // Mode must settle before run() reckons page size from it
        run(8'h85, 12'($urandom), 9'h000, 256);
        run(8'h82, 12'($urandom), 9'h000, 256);
        foreach (ops[i]) run(ops[i], 12'($urandom), 9'h000, 0);
        run(8'h84, 12'h000, 9'h0FE, 3);
        run(8'h88, 12'($urandom), 9'h000, 0);
        run(8'h02, 12'($urandom), 9'h0FE, 3);
        bin <= 1'b0;
        @(posedge clock); // Same: expected layout follows the new mode
        run(8'h87, 12'h000, 9'h100, 8);
        run(8'h89, 12'($urandom), 9'h000, 0);
        run(8'h02, 12'($urandom), 9'h106, 3);
        run(8'h02, 12'($urandom), 9'h000, 0);
        fail_en <= 1'b1;
        run(8'h02, 12'($urandom), 9'h005, 1);
        chk(32'h1, {31'h0, erase_program_error_flag});
        fail_en <= 1'b0;
        run(8'h86, 12'($urandom), 9'h000, 0);
        chk(32'h0, {31'h0, erase_program_error_flag});
        print_verdict;
    end
    // Watchdog well past the expected run length
    initial begin
        #240000;
        fail("watchdog expired");
        print_verdict;
    end
endmodule // tb
